// ---- inc/fscr_defs.svh ----
// Constants for the frame scrambler and descrambler
`ifndef FSCR_DEFS_SVH
`define FSCR_DEFS_SVH

// Widths of the shift state and the data word
`define FSCR_STATE_W 58
`define FSCR_WORD_W 32

// Tap positions, with state bits numbered 58 down to 1
`define FSCR_TAP_A 58
`define FSCR_TAP_B 39
`define FSCR_WORD_TAP_A 27
`define FSCR_WORD_TAP_B 8
`define FSCR_KEEP_TOP 26

// Seed value loaded by seed_load and by reset
`define FSCR_SEED_HI 26'h0294387
`define FSCR_SEED_LO 32'h98327338

// Clock period in ns
`define FSCR_CLK_PERIOD_NS 50

`endif

// ---- inc/fscr_pkg.sv ----
// Types and shared decoding for the frame scrambler and descrambler
`include "fscr_defs.svh"

package fscr_pkg;

    typedef logic [`FSCR_STATE_W:1] fscr_state_t;
    typedef logic [`FSCR_WORD_W-1:0] fscr_word_t;

    typedef enum {
        FSCR_SCRAMBLE,
        FSCR_DESCRAMBLE
    } fscr_mode_e;

    typedef enum {
        FSCR_HOLD,
        FSCR_SEED,
        FSCR_ADVANCE
    } fscr_step_e;

    // Seed wins over bypass; bypass alone freezes the state
    function automatic fscr_step_e fscr_step_of(logic seed_load, logic pass_through_ctl);
        fscr_step_e step;
        if (seed_load) begin
            step = FSCR_SEED;
        end else if (pass_through_ctl) begin
            step = FSCR_HOLD;
        end else begin
            step = FSCR_ADVANCE;
        end
        return step;
    endfunction

endpackage

// ---- hdl/fscr_serial.sv ----
// One-bit serial scrambler or descrambler engine
`timescale 1ns/100ps
`include "fscr_defs.svh"

module fscr_serial #(
    parameter fscr_pkg::fscr_mode_e MODE = fscr_pkg::FSCR_SCRAMBLE
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Controls
    input wire logic seed_load,
    input wire logic pass_through_ctl,
    // Data
    input wire logic bit_in,
    output logic bit_out
);
    import fscr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    fscr_state_t state_reg;
    fscr_state_t state_next;
    logic mix_bit;
    logic feedback_bit;
    fscr_step_e step;

    assign step = fscr_step_of(seed_load, pass_through_ctl);

    // Output bit from the two top taps
    assign mix_bit = pass_through_ctl ? bit_in : (bit_in ^ state_reg[`FSCR_TAP_A] ^ state_reg[`FSCR_TAP_B]);

    // Descrambler feeds the line bit so it resynchronises by itself
    assign feedback_bit = (MODE == FSCR_SCRAMBLE) ? mix_bit : bit_in;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (step)
            FSCR_SEED: begin
                state_next = {`FSCR_SEED_HI, `FSCR_SEED_LO};
            end
            FSCR_ADVANCE: begin
                state_next = {state_reg[`FSCR_STATE_W-1:1], feedback_bit};
            end
            FSCR_HOLD: begin
                state_next = state_reg;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= {`FSCR_SEED_HI, `FSCR_SEED_LO};
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered so the top sees a flop on every output
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bit_out <= 1'b0;
        end else begin
            bit_out <= mix_bit;
        end
    end

endmodule

// ---- hdl/fscr_top.sv ----
// Frame scrambler and descrambler, 32-bit parallel and 1-bit serial paths
//
// Behaviour
// - The parallel engine keeps a 58-bit state and a 32-bit XOR network and takes one word per clock.
// - Output bit i is input bit i XOR state bit i+27 XOR state bit i+8, with state bits 58 down to 1.
// - On an advancing clock the new state bits 58 to 33 are the old state bits 26 to 1.
// - On an advancing clock the new state bits 32 to 1 are the feedback word, scrambled output or received input.
// - Seed load sets the upper 26 state bits to 0x00294387 and the lower 32 to 0x98327338.
// - Under bypass the input goes to the output with no XOR applied.
// - Under bypass without seed load the state is held.
// - Seed load wins over the update and reloads even in bypass; the state advances only with neither active.
// - The polynomial used is x^58 + x^39 + 1.
// - The serial variant makes each output bit as input XOR state bit 58 XOR state bit 39, one bit per clock.
// - The serial scrambler shifts the state up one, inserts the output bit at the bottom and drops bit 58.
// - The serial descrambler shifts the same way but inserts the received input bit.
`timescale 1ns/100ps
`include "fscr_defs.svh"

module fscr_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Parallel scrambler
    input wire logic tx_seed_load,
    input wire logic tx_pass_through_ctl,
    input wire fscr_pkg::fscr_word_t tx_word_in,
    output fscr_pkg::fscr_word_t tx_word_out,
    // Parallel descrambler
    input wire logic rx_seed_load,
    input wire logic rx_pass_through_ctl,
    input wire fscr_pkg::fscr_word_t rx_word_in,
    output fscr_pkg::fscr_word_t rx_word_out,
    // Serial scrambler
    input wire logic tx_bit_seed_load,
    input wire logic tx_bit_pass_through_ctl,
    input wire logic tx_bit_in,
    output logic tx_bit_out,
    // Serial descrambler
    input wire logic rx_bit_seed_load,
    input wire logic rx_bit_pass_through_ctl,
    input wire logic rx_bit_in,
    output logic rx_bit_out
);
    import fscr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared XOR network for both parallel paths
    function automatic fscr_word_t fscr_xor_tree(fscr_word_t din, fscr_state_t s);
        fscr_word_t r;
        r = din;
        for (int i = 0; i < `FSCR_WORD_W; i++) begin
            r[i] = din[i] ^ s[i+`FSCR_WORD_TAP_A] ^ s[i+`FSCR_WORD_TAP_B];
        end
        return r;
    endfunction

    // Next state for an advancing clock
    function automatic fscr_state_t fscr_shift_word(fscr_state_t s, fscr_word_t fb);
        return {s[`FSCR_KEEP_TOP:1], fb};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel scrambler
    fscr_state_t tx_state_reg;
    fscr_state_t tx_state_next;
    fscr_word_t tx_mix;
    fscr_step_e tx_step;

    assign tx_step = fscr_step_of(tx_seed_load, tx_pass_through_ctl);
    assign tx_mix = tx_pass_through_ctl ? tx_word_in : fscr_xor_tree(tx_word_in, tx_state_reg);

    always_comb begin
        tx_state_next = tx_state_reg;
        unique case (tx_step)
            FSCR_SEED: begin
                tx_state_next = {`FSCR_SEED_HI, `FSCR_SEED_LO};
            end
            FSCR_ADVANCE: begin
                // Scrambler feeds back its own output word
                tx_state_next = fscr_shift_word(tx_state_reg, tx_mix);
            end
            FSCR_HOLD: begin
                tx_state_next = tx_state_reg;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_state_reg <= {`FSCR_SEED_HI, `FSCR_SEED_LO};
        end else begin
            tx_state_reg <= tx_state_next;
        end
    end

    // Output flop adds one cycle of latency to keep ports glitch free
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_word_out <= 32'h00000000;
        end else begin
            tx_word_out <= tx_mix;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel descrambler
    fscr_state_t rx_state_reg;
    fscr_state_t rx_state_next;
    fscr_word_t rx_mix;
    fscr_step_e rx_step;

    assign rx_step = fscr_step_of(rx_seed_load, rx_pass_through_ctl);
    assign rx_mix = rx_pass_through_ctl ? rx_word_in : fscr_xor_tree(rx_word_in, rx_state_reg);

    always_comb begin
        rx_state_next = rx_state_reg;
        unique case (rx_step)
            FSCR_SEED: begin
                rx_state_next = {`FSCR_SEED_HI, `FSCR_SEED_LO};
            end
            FSCR_ADVANCE: begin
                // Line word feeds back, so a bit error spreads only to three outputs
                rx_state_next = fscr_shift_word(rx_state_reg, rx_word_in);
            end
            FSCR_HOLD: begin
                rx_state_next = rx_state_reg;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_state_reg <= {`FSCR_SEED_HI, `FSCR_SEED_LO};
        end else begin
            rx_state_reg <= rx_state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_word_out <= 32'h00000000;
        end else begin
            rx_word_out <= rx_mix;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial paths
    fscr_serial #(
        .MODE(FSCR_SCRAMBLE)
    ) u_tx_serial (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .seed_load(tx_bit_seed_load),
        .pass_through_ctl(tx_bit_pass_through_ctl),
        .bit_in(tx_bit_in),
        .bit_out(tx_bit_out)
    );

    fscr_serial #(
        .MODE(FSCR_DESCRAMBLE)
    ) u_rx_serial (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .seed_load(rx_bit_seed_load),
        .pass_through_ctl(rx_bit_pass_through_ctl),
        .bit_in(rx_bit_in),
        .bit_out(rx_bit_out)
    );

endmodule

// ---- tb/fscr_chk_sva.sv ----
// Port assertions for the frame scrambler and descrambler
`timescale 1ns/100ps
`include "fscr_defs.svh"
module fscr_chk (
    // Clock and reset
    input wire logic sys_clk, rstn,
    // Parallel paths
    input wire logic tx_seed_load, tx_pass_through_ctl, rx_seed_load, rx_pass_through_ctl,
    input wire fscr_pkg::fscr_word_t tx_word_in, tx_word_out, rx_word_in, rx_word_out,
    // Serial paths
    input wire logic tx_bit_seed_load, tx_bit_pass_through_ctl, tx_bit_in, tx_bit_out,
    input wire logic rx_bit_pass_through_ctl, rx_bit_in, rx_bit_out
);
    import fscr_pkg::*;
    localparam fscr_state_t SEED = {`FSCR_SEED_HI, `FSCR_SEED_LO};
    localparam fscr_word_t KEY = SEED[58:27] ^ SEED[39:8];
    // State is invisible here, so rebuild it from the last two feedback words
    function automatic fscr_word_t key_of(fscr_word_t a, fscr_word_t b);
        fscr_state_t s;
        s = {a[25:0], b};
        return s[58:27] ^ s[39:8];
    endfunction
    logic tx_adv, rx_adv;
    assign tx_adv = !tx_seed_load && !tx_pass_through_ctl;
    assign rx_adv = !rx_seed_load && !rx_pass_through_ctl;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    property p_tx_pass;
        tx_pass_through_ctl |=> tx_word_out == $past(tx_word_in);
    endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("tx bypass altered data");
    property p_rxb_pass;
        rx_bit_pass_through_ctl |=> rx_bit_out == $past(rx_bit_in);
    endproperty
    a_rxb_pass: assert property (p_rxb_pass) else $error("rx bit bypass altered data");
    property p_tx_seed;
        tx_seed_load ##1 tx_adv |=> tx_word_out == ($past(tx_word_in) ^ KEY);
    endproperty
    a_tx_seed: assert property (p_tx_seed) else $error("tx seed wrong");
    property p_rx_seed;
        rx_seed_load && rx_pass_through_ctl ##1 rx_adv |=> rx_word_out == ($past(rx_word_in) ^ KEY);
    endproperty
    a_rx_seed: assert property (p_rx_seed) else $error("seed under bypass lost");
    property p_txb_seed;
        tx_bit_seed_load ##1 !tx_bit_seed_load && !tx_bit_pass_through_ctl
            |=> tx_bit_out == ($past(tx_bit_in) ^ SEED[58] ^ SEED[39]);
    endproperty
    a_txb_seed: assert property (p_txb_seed) else $error("serial taps wrong");
    property p_tx_hold;
        tx_seed_load ##1 (tx_pass_through_ctl && !tx_seed_load)[*2] ##1 tx_adv
            |=> tx_word_out == ($past(tx_word_in) ^ KEY);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("state moved in bypass");
    property p_tx_chain;
        tx_adv[*2] ##1 !tx_pass_through_ctl
            |=> tx_word_out == ($past(tx_word_in) ^ key_of($past(tx_word_out, 2), $past(tx_word_out)));
    endproperty
    a_tx_chain: assert property (p_tx_chain) else $error("tx feedback wrong");
    property p_rx_chain;
        rx_adv[*2] ##1 !rx_pass_through_ctl
            |=> rx_word_out == ($past(rx_word_in) ^ key_of($past(rx_word_in, 3), $past(rx_word_in, 2)));
    endproperty
    a_rx_chain: assert property (p_rx_chain) else $error("rx shift wrong");
    c_seed_pass: cover property (rx_seed_load && rx_pass_through_ctl ##1 rx_adv);
    c_tx_run: cover property (tx_adv[*8]);
    c_txb_seed: cover property (tx_bit_seed_load ##1 !tx_bit_seed_load);
endmodule
bind fscr_top fscr_chk chk_u (.*);

// ---- tb/fscr_line.sv ----
// Line model joining scrambler outputs to descrambler inputs
`timescale 1ns/100ps
module fscr_line (
    // From the scramblers
    input wire fscr_pkg::fscr_word_t tx_word_out,
    input wire logic tx_bit_out,
    // Bit error on bit 0
    input wire logic err,
    // To the descramblers
    output fscr_pkg::fscr_word_t rx_word_in,
    output logic rx_bit_in
);
    // A flipped bit must reach both descramblers to show error spread
    assign rx_word_in = tx_word_out ^ {31'h0, err};
    assign rx_bit_in = tx_bit_out ^ err;
endmodule

// ---- tb/fscr_top_tb.sv ----
// Self-checking bench for the frame scrambler and descrambler
`timescale 1ns/100ps
`include "fscr_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module fscr_top_tb;
    import fscr_pkg::*;
    localparam fscr_state_t SEED = {`FSCR_SEED_HI, `FSCR_SEED_LO};
    logic sys_clk, rstn, err, tbi, tbo, rbi, rbo, etb, erb;
    logic [3:0] sl, pt;
    logic [15:0] r;
    fscr_word_t twi, two, rwi, rwo, etw, erw;
    fscr_state_t st[4];
    int errors, n_checks, cyc, k;
    fscr_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .tx_seed_load(sl[0]), .tx_pass_through_ctl(pt[0]),
        .tx_word_in(twi), .tx_word_out(two), .rx_seed_load(sl[1]), .rx_pass_through_ctl(pt[1]),
        .rx_word_in(rwi), .rx_word_out(rwo), .tx_bit_seed_load(sl[2]), .tx_bit_pass_through_ctl(pt[2]),
        .tx_bit_in(tbi), .tx_bit_out(tbo), .rx_bit_seed_load(sl[3]), .rx_bit_pass_through_ctl(pt[3]),
        .rx_bit_in(rbi), .rx_bit_out(rbo));
    fscr_line line_u (.tx_word_out(two), .tx_bit_out(tbo), .err(err), .rx_word_in(rwi), .rx_bit_in(rbi));
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic par(inout fscr_state_t s, input fscr_word_t d, input logic sd, ps, scr, output fscr_word_t q);
        q = ps ? d : d ^ s[58:27] ^ s[39:8];
        if (sd) s = SEED;
        else if (!ps) s = {s[26:1], scr ? q : d};
    endtask
    task automatic ser(inout fscr_state_t s, input logic d, sd, ps, scr, output logic q);
        q = ps ? d : d ^ s[58] ^ s[39];
        if (sd) s = SEED;
        else if (!ps) s = {s[57:1], scr ? q : d};
    endtask
    task automatic tally_and_finish();
        int fails;
        // Timeout counted here, so only the stimulus process writes errors
        fails = errors + int'(cyc >= 1000);
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Run is about 420 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end
    initial begin
        {rstn, err, sl, pt, tbi, twi, etw, erw, etb, erb} = '0;
        {errors, n_checks} = '0;
        st = '{SEED, SEED, SEED, SEED};
        r = 16'h0010;
        repeat (20) @(negedge sys_clk);
        for (int t = 0; t < 4; t++) begin
            for (int c = 0; c < 100; c++) begin
                @(negedge sys_clk);
                `CHK(two, etw)
                `CHK(rwo, erw)
                `CHK(tbo, etb)
                `CHK(rbo, erb)
                r = lfsr(r);
                twi = {r, lfsr(r)};
                tbi = r[7];
                r = lfsr(r);
                k = c % 25;
                // Corners: seed, bypass hold, seed under bypass
                sl = k == 0 ? 4'hf : k < 4 ? 4'h0 : r[3:0] & r[7:4] & r[11:8];
                pt = k == 0 ? {r[13:12], 1'b1, r[14]} : k < 3 ? 4'h1 : k < 4 ? 4'h0 : r[15:12] & r[9:6];
                if (t == 1 && k > 3) {sl, pt} = '0;
                err = t == 3 && c == 40;
                rstn = !(t == 2 && (c == 50 || c == 51));
                if (!rstn) begin
                    {etw, erw, etb, erb} = '0;
                    st = '{SEED, SEED, SEED, SEED};
                end else begin
                    // Line carries the expected scrambler output now standing, plus the new error bit
                    par(st[1], etw ^ {31'h0, err}, sl[1], pt[1], 1'b0, erw);
                    ser(st[3], etb ^ err, sl[3], pt[3], 1'b0, erb);
                    par(st[0], twi, sl[0], pt[0], 1'b1, etw);
                    ser(st[2], tbi, sl[2], pt[2], 1'b1, etb);
                end
            end
            $display("test %0d done", t);
        end
        tally_and_finish();
    end
endmodule
